// File: pkg/dss_consts.svh
/*
  Constants of the drive start-control sequencer: time bases, setting
  limits, defaults and command-source codes.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH

// ==========================================================
// Time base
`define DSS_CLK_KHZ          20000
`define DSS_TICK_MS          10
`define DSS_TICK_CYC         (`DSS_TICK_MS * `DSS_CLK_KHZ)
`define DSS_TWO_MIN_S        120
`define DSS_TWO_MIN_TICKS    (`DSS_TWO_MIN_S * 1000 / `DSS_TICK_MS)
`define DSS_IVAL_STEP_MS     100
`define DSS_IVAL_STEP_TICKS  (`DSS_IVAL_STEP_MS / `DSS_TICK_MS)
`define DSS_DEAD_STEP_MS     10
`define DSS_DEAD_STEP_TICKS  (`DSS_DEAD_STEP_MS / `DSS_TICK_MS)
// Power-up window, longer than the pin synchroniser latency
`define DSS_PWR_WINDOW       3'h6

// ==========================================================
// Setting limits and defaults
`define DSS_COUNT_MAX        7'h64
`define DSS_DEAD_MAX         16'h8ca0
`define DSS_DEAD_DEFAULT     16'h0001
`define DSS_IVAL_DEFAULT     14'h0032

// ==========================================================
// Run command sources
`define DSS_SRC_KEYPAD       2'h0
`define DSS_SRC_TERMINAL     2'h1
`define DSS_SRC_SERIAL       2'h2

`endif

// File: pkg/dss_pkg.sv
/*
  Types of the drive start-control sequencer.
  Assumes nothing beyond the constants header.
*/
`include "dss_consts.svh"

package dss_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_DEAD,
    ST_WAIT,
    ST_LOCK,
    ST_PROTECT
  } dss_state_t;

  // Run request as one unit
  typedef struct packed {
    logic run;
    logic reverse_direction_input;
  } dss_cmd_t;

  // Operator terminal levels after synchronising
  typedef struct packed {
    logic forward_run_input;
    logic reverse_direction_input;
    logic hold;
  } dss_term_t;

endpackage : dss_pkg

// File: design/dss_pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pin levels and one system clock.
*/
`timescale 1ns/1ns

module dss_pin_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // Pins and clean levels
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // ==========================================================
  // Accept a change only where stages two and three agree
  always_comb
  begin
    next_level = level_o;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
        next_level[i] = s3[i];
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s1      <= '0;
      s2      <= '0;
      s3      <= '0;
      level_o <= '0;
    end
    else
    begin
      s1      <= pin_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= next_level;
    end
  end

endmodule : dss_pin_sync

// File: design/dss_sequencer.sv
/*
  Drive start-control sequencer: source select, auto fault reset,
  two-wire start protection, two/three-wire terminals, dead zone.
  Assumes terminal pins are asynchronous; all other inputs are on clk_i.
*/
// Function
// - Run commands from keypad, terminal or serial
// - Source changeable anytime by terminal or setting
// - Count zero means immediate fault lock
// - Two fault-free minutes of running clear used reset count
// - Module and external faults never auto reset
// - Auto reset restarts with speed-tracking start
// - Auto reset at interval, up to count
// - Reset count accepted from 0 to 100
// - Start protection only for two-wire terminals
// - Selection 0 holds until run re-asserted
// - Selection 1 starts with speed tracking
// - Dead zone 0.00 to 360.00 s, 0.01 step
// - Two-wire terminals give direction and run
// - Three-wire starts on forward edge, hold closed
// - Three-wire stops when hold input opens
// - Speed-tracking start flagged for smooth restart
`timescale 1ns/1ns
`include "dss_consts.svh"

module dss_sequencer
  import dss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DSS_TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Source selection
  input  wire logic [1:0]  run_source_select_i,
  input  wire logic        source_force_en_i,
  input  wire logic [1:0]  source_force_sel_i,
  input  wire logic        three_wire_mode_i,
  // Keypad and serial commands
  input  wire logic        key_run_i,
  input  wire logic        key_stop_i,
  input  wire logic        key_rev_i,
  input  wire logic        serial_run_i,
  input  wire logic        serial_rev_i,
  // Operator terminal pins
  input  wire logic        forward_run_input_i,
  input  wire logic        reverse_direction_input_i,
  input  wire logic        stop_hold_input_i,
  // Settings
  input  wire logic        terminal_start_protection_select_i,
  input  wire logic [6:0]  auto_reset_count_setting_i,
  input  wire logic [13:0] auto_reset_interval_setting_i,
  input  wire logic [15:0] direction_dead_zone_time_i,
  // Faults
  input  wire logic        module_protection_fault_i,
  input  wire logic        external_equipment_fault_i,
  input  wire logic        other_fault_i,
  input  wire logic        manual_reset_i,
  // Drive status
  output logic             run_o,
  output logic             dir_rev_o,
  output logic             zero_freq_hold_o,
  output logic             speed_track_start_o,
  output logic             fault_lock_o,
  output logic             run_protect_o,
  output logic [6:0]       reset_used_o,
  output logic [1:0]       active_source_o
);

  // ==========================================================
  // Interval setting in tenths of a second to 10 ms ticks
  function automatic logic [16:0] dss_ival_ticks(input logic [13:0] v);
    dss_ival_ticks = 17'(v * `DSS_IVAL_STEP_TICKS);
  endfunction : dss_ival_ticks

  dss_state_t  state, next_state;
  dss_term_t   term;
  dss_cmd_t    cmd;
  logic [17:0] div, next_div;
  logic        tick;
  logic [16:0] timer, next_timer;
  logic [13:0] fine, next_fine;
  logic [6:0]  used, next_used, count;
  logic        key_run, next_key_run, wire3_run, next_wire3_run;
  logic        fwd_q;
  logic [2:0]  pwr_pend, next_pwr_pend;
  logic [1:0]  src, src_q;
  logic        dir, next_dir, next_track;
  logic        fault_any, fault_hard, two_wire_term, prot_evt, prot_hit;
  logic [16:0] dead_ticks;

  dss_pin_sync #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   ({forward_run_input_i, reverse_direction_input_i,
               stop_hold_input_i}),
    .level_o (term)
  );

  // ==========================================================
  // Source choice and decoded run request
  always_comb
  begin
    src = source_force_en_i ? source_force_sel_i
                            : run_source_select_i;
    count = (auto_reset_count_setting_i > `DSS_COUNT_MAX)
          ? `DSS_COUNT_MAX : auto_reset_count_setting_i;
    dead_ticks = (direction_dead_zone_time_i > `DSS_DEAD_MAX)
          ? 17'(`DSS_DEAD_MAX * `DSS_DEAD_STEP_TICKS)
          : 17'(direction_dead_zone_time_i * `DSS_DEAD_STEP_TICKS);
    two_wire_term = (src == `DSS_SRC_TERMINAL) && !three_wire_mode_i;
    fault_hard = module_protection_fault_i | external_equipment_fault_i;
    fault_any  = fault_hard | other_fault_i;
    next_key_run = key_stop_i ? 1'b0 : (key_run_i ? 1'b1 : key_run);
    // Stop wins: hold open clears the latch even on a forward edge
    next_wire3_run = !term.hold ? 1'b0
                   : ((term.forward_run_input && !fwd_q) ? 1'b1 : wire3_run);
    case (src)
      `DSS_SRC_KEYPAD:   cmd = '{run: key_run, reverse_direction_input: key_rev_i};
      `DSS_SRC_SERIAL:   cmd = '{run: serial_run_i, reverse_direction_input: serial_rev_i};
      `DSS_SRC_TERMINAL:
        if (three_wire_mode_i)
          cmd = '{run: wire3_run && term.hold, reverse_direction_input: term.reverse_direction_input};
        else
          cmd = '{run: term.forward_run_input ^ term.reverse_direction_input, reverse_direction_input: term.reverse_direction_input};
      default:           cmd = '{run: 1'b0, reverse_direction_input: 1'b0};
    endcase
    // Power-up or switch into two-wire terminal control
    prot_evt = (pwr_pend != 3'h0) ||
               (src == `DSS_SRC_TERMINAL && src_q != `DSS_SRC_TERMINAL);
    prot_hit = prot_evt && two_wire_term && cmd.run;
  end

  // ==========================================================
  // Sequencer next state
  always_comb
  begin
    next_state    = state;
    next_timer    = timer;
    next_fine     = fine;
    next_used     = used;
    next_dir      = dir;
    next_track    = 1'b0;
    // Window outlasts the pin synchroniser, which restarts from zero
    next_pwr_pend = (pwr_pend != 3'h0) ? pwr_pend - 3'h1 : 3'h0;
    tick          = (div == 18'(TICK_CYCLES - 1));
    next_div      = tick ? 18'h00000 : div + 18'h00001;
    if (tick && timer != 17'h00000)
      next_timer = timer - 17'h00001;
    // Fault-free running time
    if ((state == ST_RUN || state == ST_DEAD) && tick)
    begin
      if (fine == 14'(`DSS_TWO_MIN_TICKS - 1))
      begin
        next_fine = 14'h0000;
        next_used = 7'h00;
      end
      else
        next_fine = fine + 14'h0001;
    end
    case (state)
      ST_IDLE, ST_RUN, ST_DEAD, ST_PROTECT:
      begin
        if (fault_any)
        begin
          next_fine = 14'h0000;
          if (fault_hard || count == 7'h00 || used >= count)
            next_state = ST_LOCK;
          else
          begin
            next_state = ST_WAIT;
            next_timer = dss_ival_ticks(auto_reset_interval_setting_i);
          end
        end
        else if (prot_hit && state != ST_PROTECT)
        begin
          if (!terminal_start_protection_select_i)
            next_state = ST_PROTECT;
          else if (state == ST_IDLE)
          begin
            next_state = ST_RUN;
            next_dir   = cmd.reverse_direction_input;
            next_track = 1'b1;
          end
        end
        else if (state == ST_PROTECT)
        begin
          if (!cmd.run)
            next_state = ST_IDLE;
        end
        else if (!cmd.run)
          next_state = ST_IDLE;
        else if (state == ST_IDLE)
        begin
          next_state = ST_RUN;
          next_dir   = cmd.reverse_direction_input;
        end
        else if (state == ST_RUN && cmd.reverse_direction_input != dir)
        begin
          if (dead_ticks == 17'h00000)
            next_dir = cmd.reverse_direction_input;
          else
          begin
            next_state = ST_DEAD;
            next_timer = dead_ticks;
          end
        end
        else if (state == ST_DEAD && timer == 17'h00000)
        begin
          next_state = ST_RUN;
          next_dir   = cmd.reverse_direction_input;
        end
      end
      ST_WAIT:
      begin
        if (fault_hard)
          next_state = ST_LOCK;
        else if (timer == 17'h00000)
        begin
          next_used = used + 7'h01;
          if (!other_fault_i)
          begin
            next_state = ST_RUN;
            next_dir   = dir;
            next_track = 1'b1;
          end
          else if (used + 7'h01 >= count)
            next_state = ST_LOCK;
          else
            next_timer = dss_ival_ticks(auto_reset_interval_setting_i);
        end
      end
      ST_LOCK:
      begin
        if (manual_reset_i && !fault_any)
        begin
          next_used = 7'h00;
          if (two_wire_term && cmd.run)
          begin
            if (terminal_start_protection_select_i)
            begin
              next_state = ST_RUN;
              next_dir   = cmd.reverse_direction_input;
              next_track = 1'b1;
            end
            else
              next_state = ST_PROTECT;
          end
          else
            next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Registers; outputs follow next values so they stay flop-driven
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state               <= ST_IDLE;
      div                 <= 18'h00000;
      timer               <= 17'h00000;
      fine                <= 14'h0000;
      used                <= 7'h00;
      dir                 <= 1'b0;
      key_run             <= 1'b0;
      wire3_run           <= 1'b0;
      fwd_q               <= 1'b0;
      pwr_pend            <= `DSS_PWR_WINDOW;
      src_q               <= `DSS_SRC_KEYPAD;
      run_o               <= 1'b0;
      dir_rev_o           <= 1'b0;
      zero_freq_hold_o    <= 1'b0;
      speed_track_start_o <= 1'b0;
      fault_lock_o        <= 1'b0;
      run_protect_o       <= 1'b0;
      reset_used_o        <= 7'h00;
      active_source_o     <= `DSS_SRC_KEYPAD;
    end
    else
    begin
      state               <= next_state;
      div                 <= next_div;
      timer               <= next_timer;
      fine                <= next_fine;
      used                <= next_used;
      dir                 <= next_dir;
      key_run             <= next_key_run;
      wire3_run           <= next_wire3_run;
      fwd_q               <= term.forward_run_input;
      pwr_pend            <= next_pwr_pend;
      src_q               <= src;
      run_o               <= (next_state == ST_RUN);
      dir_rev_o           <= next_dir;
      zero_freq_hold_o    <= (next_state == ST_DEAD);
      speed_track_start_o <= next_track;
      fault_lock_o        <= (next_state == ST_LOCK);
      run_protect_o       <= (next_state == ST_PROTECT);
      reset_used_o        <= next_used;
      active_source_o     <= src;
    end
  end

  // ==========================================================
  // Checks
  sequence s_healthy_fault;
    (state inside {ST_IDLE, ST_RUN, ST_DEAD, ST_PROTECT}) && fault_any;
  endsequence

  sequence s_dir_flip;
    state == ST_RUN && cmd.run && cmd.reverse_direction_input != dir && !fault_any &&
    !prot_hit && dead_ticks != 17'h00000;
  endsequence

  a_zero_count_lock: assert property (@(posedge clk_i) disable iff (srst_i)
    s_healthy_fault and count == 7'h00 |=> fault_lock_o)
    else $error("fault with zero count did not lock");
  a_hard_fault_lock: assert property (@(posedge clk_i) disable iff (srst_i)
    fault_hard && state != ST_LOCK |=> state == ST_LOCK)
    else $error("non-resettable fault did not lock");
  a_lock_holds: assert property (@(posedge clk_i) disable iff (srst_i)
    state == ST_LOCK && !manual_reset_i |=> state == ST_LOCK)
    else $error("fault lock left without manual reset");
  a_auto_restart: assert property (@(posedge clk_i) disable iff (srst_i)
    state == ST_WAIT && timer == 17'h00000 && !fault_any
    |=> run_o && speed_track_start_o && state == ST_RUN)
    else $error("auto reset did not restart with tracking");
  a_used_bound: assert property (@(posedge clk_i) disable iff (srst_i)
    state == ST_WAIT |-> used < count)
    else $error("reset waited beyond configured count");
  a_protect_stay: assert property (@(posedge clk_i) disable iff (srst_i)
    state == ST_PROTECT && cmd.run && !fault_any
    |=> run_protect_o && !run_o)
    else $error("protection released with run held");
  a_dead_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    s_dir_flip |=> zero_freq_hold_o && !run_o && state == ST_DEAD)
    else $error("direction change skipped dead zone");
  a_three_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    three_wire_mode_i && src == `DSS_SRC_TERMINAL && !term.hold &&
    state == ST_RUN && $stable(src) ##1 $stable(src) |=> !run_o)
    else $error("open hold input did not stop drive");
  a_two_min_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    state == ST_RUN && !fault_any && tick &&
    fine == 14'(`DSS_TWO_MIN_TICKS - 1) |=> reset_used_o == 7'h00)
    else $error("used count not cleared after two minutes");

endmodule : dss_sequencer

// File: sim/dss_opr_model.sv
/*
  Operator terminal model: start and stop buttons, direction switch.
  Assumes the bench gives operator intent as levels at falling edges.
*/
`timescale 1ns/1ns

module dss_opr_model
  import dss_pkg::*;
(
  // Mode and operator intent
  input  wire logic three_wire_i,
  input  wire logic run_cmd_i,
  input  wire logic rev_cmd_i,
  input  wire logic stop_cmd_i,
  // Terminal contacts, high when closed
  output dss_term_t pins_o
);
  // ==========================================================
  // Contact wiring
  // Three-wire keeps the stop contact closed unless a stop is asked
  // for, so a start press is only ever a forward edge under a hold
  always_comb
  begin
    if (three_wire_i)
    begin
      pins_o.forward_run_input  = run_cmd_i;
      pins_o.reverse_direction_input  = rev_cmd_i;
      pins_o.hold = ~stop_cmd_i;
    end
    else
    begin
      pins_o.forward_run_input  = run_cmd_i & ~rev_cmd_i;
      pins_o.reverse_direction_input  = run_cmd_i & rev_cmd_i;
      pins_o.hold = 1'b0;
    end
  end
endmodule : dss_opr_model

// File: sim/testbench.sv
/*
  Self-checking bench for the start-control sequencer.
  Assumes the operator model drives the pins; tick shortened to 4 cycles.
*/
`timescale 1ns/1ns
`include "dss_consts.svh"

module testbench
  import dss_pkg::*;
;
  // ==========================================================
  // Signals
  localparam int TICK     = 4;
  localparam int IVAL_CYC = `DSS_IVAL_STEP_TICKS * TICK;
  typedef struct packed {
    logic [1:0] src;
    logic       frc, key, ser, trm, reverse_direction_input, e_run, e_rev;
    logic [1:0] e_src;
  } dss_row_t;
  logic        clk = 1'b0, srst = 1'b1, run, dir, zhold, trk_p, lock, prot;
  logic [1:0]  src_sel = 2'h0, src_o, frc_sel = 2'h2;
  logic        frc_en = 1'b0, three_w = 1'b0, prot_sel = 1'b0, reverse_direction_input = 1'b0;
  logic        key_run = 1'b0, key_stop = 1'b0, ser_run = 1'b0;
  logic        run_cmd = 1'b0, stop_cmd = 1'b0, man_rst = 1'b0;
  logic        f_mod = 1'b0, f_ext = 1'b0, f_oth = 1'b0;
  logic [6:0]  cnt_set = 7'h00, used;
  logic [13:0] ival = 14'h0001;
  logic [15:0] dead = `DSS_DEAD_DEFAULT;
  dss_term_t   pins;
  int          miscompares = 0, comparisons = 0, trk = 0, n;
  // Source, commands, expected run, direction and source
  dss_row_t    rows [9] = '{
    '{2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 2'h0},
    '{2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0},
    '{2'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 2'h2},
    '{2'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 2'h2},
    '{2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h1},
    '{2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h1},
    '{2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0},
    '{2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 2'h2},
    '{2'h3, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3}};

  // ==========================================================
  // Far side and design
  dss_opr_model opr_u (
    .three_wire_i (three_w), .run_cmd_i (run_cmd),
    .rev_cmd_i    (reverse_direction_input),     .stop_cmd_i (stop_cmd), .pins_o (pins));
  dss_sequencer #(.TICK_CYCLES (TICK)) dut_u (
    .clk_i (clk), .srst_i (srst), .run_source_select_i (src_sel),
    .source_force_en_i (frc_en), .source_force_sel_i (frc_sel),
    .three_wire_mode_i (three_w), .key_run_i (key_run),
    .key_stop_i (key_stop), .key_rev_i (reverse_direction_input), .serial_run_i (ser_run),
    .serial_rev_i (reverse_direction_input), .forward_run_input_i (pins.forward_run_input),
    .reverse_direction_input_i (pins.reverse_direction_input), .stop_hold_input_i (pins.hold),
    .terminal_start_protection_select_i (prot_sel),
    .auto_reset_count_setting_i (cnt_set),
    .auto_reset_interval_setting_i (ival),
    .direction_dead_zone_time_i (dead),
    .module_protection_fault_i (f_mod), .external_equipment_fault_i (f_ext),
    .other_fault_i (f_oth), .manual_reset_i (man_rst), .run_o (run),
    .dir_rev_o (dir), .zero_freq_hold_o (zhold),
    .speed_track_start_o (trk_p), .fault_lock_o (lock),
    .run_protect_o (prot), .reset_used_o (used), .active_source_o (src_o));

  // Clock at 20 MHz
  always #25 clk = ~clk;
  // Tracking starts are one-cycle pulses, so count them as they pass
  always @(posedge clk)
    if (trk_p === 1'b1)
      trk <= trk + 1;

  // ==========================================================
  // Tasks
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic stop_all();
    {key_run, ser_run, run_cmd, key_stop} = 4'h1;
    cyc(1);
    key_stop = 1'b0;
    cyc(8);
  endtask : stop_all
  task automatic run_key();
    key_run = 1'b1;
    cyc(1);
    key_run = 1'b0;
    cyc(4);
  endtask : run_key
  // Bounded wait, so a drive that never restarts cannot hang the run
  task automatic wait_run(output int cnt);
    cnt = 0;
    while (run !== 1'b1 && cnt < 200)
    begin
      cyc(1);
      cnt++;
    end
  endtask : wait_run
  task automatic auto_step(input logic [6:0] exp_used);
    int c;
    int t;
    t = trk;
    f_oth = 1'b1;
    cyc(2);
    f_oth = 1'b0;
    wait_run(c);
    cyc(1);
    check("interval", c >= IVAL_CYC - 8 && c <= IVAL_CYC + 8, 1'b1);
    check("used", used, exp_used);
    check("tracking", 16'(trk - t), 16'h0001);
  endtask : auto_step
  task automatic man_reset();
    man_rst = 1'b1;
    cyc(1);
    man_rst = 1'b0;
    cyc(3);
    check("unlock", lock, 1'b0);
  endtask : man_reset
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d miscompares",
             comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ==========================================================
  // Main sequence
  initial
  begin
    cyc(5);
    srst = 1'b0;
    cyc(1);
    check("reset", {run, lock, prot, used, src_o}, 16'h0000);
    $display("Test done: reset");
    // Table of plain commands, one row at a time from standstill
    for (int i = 0; i < 9; i++)
    begin
      {src_sel, frc_en, reverse_direction_input} = {rows[i].src, rows[i].frc, rows[i].reverse_direction_input};
      cyc(2);
      {key_run, ser_run, run_cmd} = {rows[i].key, rows[i].ser, rows[i].trm};
      cyc(10);
      check("run", run, rows[i].e_run);
      if (rows[i].e_run)
        check("dir", dir, rows[i].e_rev);
      check("source", src_o, rows[i].e_src);
      stop_all();
    end
    $display("Test done: table");
    // Reversal while running: zero hold for three ticks
    {src_sel, dead, reverse_direction_input} = {2'h0, 16'h0003, 1'b0};
    run_key();
    reverse_direction_input = 1'b1;
    cyc(2);
    check("zero hold", {zhold, run}, 16'h0002);
    wait_run(n);
    check("dead span", n >= 3 * TICK - 4 && n <= 3 * TICK + 6, 1'b1);
    check("new dir", dir, 1'b1);
    stop_all();
    {reverse_direction_input, cnt_set} = {1'b0, 7'h02};
    $display("Test done: dead zone");
    // Auto resets, two-minute clear, exhaustion
    run_key();
    auto_step(7'h01);
    cyc(`DSS_TWO_MIN_TICKS * TICK + 2 * TICK);
    check("used clear", used, 7'h00);
    auto_step(7'h01);
    auto_step(7'h02);
    f_oth = 1'b1;
    cyc(2);
    f_oth = 1'b0;
    cyc(IVAL_CYC + 20);
    check("exhausted", {lock, run}, 16'h0002);
    man_reset();
    check("used", used, 7'h00);
    // Count zero, then the two faults that never auto reset
    for (int k = 0; k < 3; k++)
    begin
      cnt_set = (k == 0) ? 7'h00 : 7'h02;
      run_key();
      {f_oth, f_mod, f_ext} = 3'h4 >> k;
      cyc(2);
      {f_oth, f_mod, f_ext} = 3'h0;
      cyc(IVAL_CYC + 20);
      check("hard lock", {lock, run}, 16'h0002);
      man_reset();
    end
    stop_all();
    $display("Test done: faults");
    // Switch into two-wire terminals with run held, both selections
    run_cmd = 1'b1;
    cyc(8);
    src_sel = 2'h1;
    cyc(4);
    check("protect", {prot, run}, 16'h0002);
    run_cmd = 1'b0;
    cyc(8);
    run_cmd = 1'b1;
    cyc(8);
    check("rerun", {prot, run}, 16'h0001);
    stop_all();
    // Keypad selected, then the terminal forced in by the switch input
    {src_sel, prot_sel, run_cmd} = {2'h0, 1'b1, 1'b1};
    cyc(8);
    n = trk;
    {frc_sel, frc_en} = {2'h1, 1'b1};
    cyc(4);
    check("track run", run, 1'b1);
    check("track pulse", 16'(trk - n), 16'h0001);
    stop_all();
    $display("Test done: start protection");
    // Three-wire: edge start under closed hold, stop on open hold
    {src_sel, frc_en, three_w, reverse_direction_input} = {2'h0, 1'b0, 1'b1, 1'b1};
    cyc(8);
    src_sel = 2'h1;
    cyc(4);
    run_cmd = 1'b1;
    cyc(8);
    run_cmd = 1'b0;
    cyc(8);
    check("three run", {run, dir}, 16'h0003);
    stop_cmd = 1'b1;
    cyc(8);
    check("three stop", run, 1'b0);
    $display("Test done: three-wire");
    // Reset after the three-wire stop, two-wire terminal run held: power-up protection
    {srst, three_w, stop_cmd, prot_sel, run_cmd} = 5'h11;
    cyc(5);
    check("reset outputs", {run, zhold, lock, prot, used}, 16'h0000);
    srst = 1'b0;
    cyc(10);
    check("power-up protect", {prot, run}, 16'h0002);
    $display("Test done: power-up protection");
    conclude();
  end

  // Watchdog: two-minute wait plus 10000 cycles for the other scenarios
  initial
  begin
    repeat (`DSS_TWO_MIN_TICKS * TICK + 10000) @(posedge clk);
    miscompares++;
    $display("Watchdog expired");
    conclude();
  end
endmodule : testbench
